// >>> src/brm_pkg.sv
`default_nettype none
package brm_pkg;

    // Datapath width and the instruction word width.
    localparam int DATA_W = 8;
    localparam int INSTR_W = 16;

    // Quarter-cycles in one instruction cycle.
    localparam int QUARTERS_PER_CYCLE = 4;
    // Oscillator periods in one instruction cycle.
    localparam int OSC_PERIODS_PER_CYCLE = 2;
    // Transitions of one oscillator input seen in one instruction cycle.
    localparam int OSC_EDGES_PER_CYCLE = 2 * OSC_PERIODS_PER_CYCLE;

    // Instruction bits are numbered with bit 0 as the most significant bit.
    // Bits 5 to 7 (rotate code for an I/O source) sit at vector index 10 down to 8.
    localparam int INSTR_ROT_HI = 10;
    localparam int INSTR_ROT_LO = 8;
    // Bits 13 to 15 (destination bit position) sit at vector index 2 down to 0.
    localparam int INSTR_POS_HI = 2;
    localparam int INSTR_POS_LO = 0;

    // A position code of seven names the least significant bit: no move.
    localparam logic [2:0] CODE_LSB = 3'h7;
    // A length field of zero stands for a full byte.
    localparam logic [2:0] LEN_FULL_CODE = 3'h0;
    localparam logic [3:0] LEN_FULL = 4'h8;

    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_INSTR = 16'h0000;

    typedef enum {
        BRM_Q1,
        BRM_Q2,
        BRM_Q3,
        BRM_Q4
    } brm_quarter_t;

    // Operand routing and fields decoded from the instruction.
    typedef struct packed {
        logic src_io;
        logic dst_io;
        logic [2:0] r_field;
        logic [2:0] len_field;
    } brm_ctl_t;

    // Drive of the I/O bus data lines.
    typedef struct packed {
        logic oe;
        logic [7:0] data;
    } brm_io_drive_t;

endpackage
`default_nettype wire

// >>> src/brm_rotate_mask.sv
`default_nettype none
module brm_rotate_mask
    import brm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Operand and controls.
    input wire logic [WIDTH-1:0] i_data,
    input wire logic [2:0] i_amount,
    input wire logic i_mask_en,
    input wire logic [3:0] i_len,
    // Result toward the ALU A input.
    output logic [WIDTH-1:0] o_data
);

    generate
        if (WIDTH != DATA_W) begin : g_bad_width
            $error("brm_rotate_mask supports an eight-bit datapath only.");
        end
    endgenerate

    logic [2*WIDTH-1:0] doubled;
    logic [2*WIDTH-1:0] shifted;
    logic [WIDTH-1:0] rotated;

    // End-around right rotate by reading the byte twice over.
    assign doubled = {i_data, i_data};
    assign shifted = doubled >> i_amount;
    assign rotated = shifted[WIDTH-1:0];

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_mask
            // Bits at or above the length are forced to zero when masking.
            assign o_data[gi] = rotated[gi] & (~i_mask_en | (4'(gi) < i_len));
        end
    endgenerate

endmodule
`default_nettype wire

// >>> src/brm_shift_merge.sv
`default_nettype none
module brm_shift_merge
    import brm_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // ALU result, original byte and controls.
    input wire logic [WIDTH-1:0] i_result,
    input wire logic [WIDTH-1:0] i_orig,
    input wire logic [2:0] i_amount,
    input wire logic [3:0] i_len,
    // Merged byte and the field that was replaced.
    output logic [WIDTH-1:0] o_data,
    output logic [WIDTH-1:0] o_mask
);

    generate
        if (WIDTH != DATA_W) begin : g_bad_width
            $error("brm_shift_merge supports an eight-bit datapath only.");
        end
    endgenerate

    logic [WIDTH-1:0] shifted;
    logic [WIDTH-1:0] field;

    // Plain left shift; bits pushed past the top are dropped.
    assign shifted = i_result << i_amount;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_field
            assign field[gi] = 4'(gi) < i_len;
        end
    endgenerate

    assign o_mask = field << i_amount;
    assign o_data = (i_orig & ~o_mask) | (shifted & o_mask);

endmodule
`default_nettype wire

// >>> src/brm_bit_datapath.sv
`default_nettype none
// Functional notes
// [RULE_01] Rotate and mask feed the ALU A input; shift and merge follow the ALU.
// [RULE_02] Register source and register destination: rotate all eight bits, never mask.
// [RULE_03] Rotate the source byte right end-around so the wanted low bit reaches LSB.
// [RULE_04] Rotate code comes from the R field, or instruction bits 5-7 for I/O sources.
// [RULE_05] The rotate code names the source bit landing at position seven; bit zero is MSB.
// [RULE_06] I/O sources pass only the lowest length-field bits; all others become zero.
// [RULE_07] The left shift never wraps; bits pushed past bit zero are lost.
// [RULE_08] Shift the ALU result left until its LSB sits at instruction bits 13-15.
// [RULE_09] Merge replaces only the length-field bits from the shifted LSB; others kept.
// [RULE_10] The I/O bus moves whole bytes only, each read byte held in the I/O latch.
// [RULE_11] Shifted bits merge into the original byte still held in the I/O latch.
// [RULE_12] The merge always uses the byte latched from this cycle's source; code uses the I/O byte latched in Q1 even for register sources.
// [RULE_13] Four quarter-cycles per instruction, paced by the internal system clock.
// [RULE_14] Internal latches follow their input while their phase is active.
// [RULE_15] One instruction cycle lasts two oscillator periods.
// [RULE_16] An external pulse source drives the two oscillator inputs complementarily.
// [RULE_17] Code seven leaves the operand unrotated and the ALU result unshifted.
module brm_bit_datapath
    import brm_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Oscillator pins.
    input wire logic i_osc_input_a,
    input wire logic i_osc_input_b,
    // Instruction word and decoded routing.
    input wire logic [15:0] i_instr,
    input wire brm_ctl_t i_ctl,
    // Operands.
    input wire logic [7:0] i_reg_data,
    input wire logic [7:0] i_io_data,
    input wire logic [7:0] i_alu_result,
    // ALU A operand.
    output logic [7:0] o_alu_a,
    // I/O bus drive.
    output brm_io_drive_t o_io,
    // Sequencing and status.
    output logic [1:0] o_quarter,
    output logic o_cycle_start,
    output logic o_osc_fault
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // Places to move so that a bit named by code lands at or leaves position seven.
    function automatic logic [2:0] code_to_places(input logic [2:0] code);
        return CODE_LSB - code; // RULE_17
    endfunction

    function automatic logic [3:0] len_decode(input logic [2:0] len_field);
        return (len_field == LEN_FULL_CODE) ? LEN_FULL : {1'b0, len_field};
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    logic osc_a_meta;
    logic osc_a_sync;
    logic osc_a_prev;
    logic osc_b_meta;
    logic osc_b_sync;
    logic [7:0] io_meta;
    logic [7:0] io_sync;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            osc_a_meta <= 1'b0;
            osc_a_sync <= 1'b0;
            osc_a_prev <= 1'b0;
            osc_b_meta <= 1'b1;
            osc_b_sync <= 1'b1;
            io_meta <= RST_BYTE;
            io_sync <= RST_BYTE;
        end else begin
            osc_a_meta <= i_osc_input_a;
            osc_a_sync <= osc_a_meta;
            osc_a_prev <= osc_a_sync;
            osc_b_meta <= i_osc_input_b;
            osc_b_sync <= osc_b_meta;
            io_meta <= i_io_data;
            io_sync <= io_meta;
        end
    end

    // Each transition of the oscillator is one transition of the system clock.
    logic sys_edge;
    assign sys_edge = osc_a_sync ^ osc_a_prev; // RULE_15

    ////////////////////////////////////////////////////////////////////////////
    // Quarter-cycle sequencer.

    brm_quarter_t quarter;
    brm_quarter_t next_quarter;
    logic next_cycle_start;
    logic next_osc_fault;
    logic [1:0] next_quarter_code;

    always_comb begin
        next_quarter = quarter;
        next_cycle_start = 1'b0;
        if (sys_edge) begin
            case (quarter) // RULE_13
                BRM_Q1: next_quarter = BRM_Q2;
                BRM_Q2: next_quarter = BRM_Q3;
                BRM_Q3: next_quarter = BRM_Q4;
                BRM_Q4: begin
                    next_quarter = BRM_Q1;
                    next_cycle_start = 1'b1;
                end
                default: next_quarter = BRM_Q4;
            endcase
        end
        // The pulse source must keep the two inputs complementary.
        next_osc_fault = osc_a_sync == osc_b_sync; // RULE_16
        // The quarter number leaves from its own flop, in step with the state.
        case (next_quarter)
            BRM_Q1: next_quarter_code = 2'h0;
            BRM_Q2: next_quarter_code = 2'h1;
            BRM_Q3: next_quarter_code = 2'h2;
            BRM_Q4: next_quarter_code = 2'h3;
            default: next_quarter_code = 2'h0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            quarter <= BRM_Q4;
            o_quarter <= 2'h3;
            o_cycle_start <= 1'b0;
            o_osc_fault <= 1'b0;
        end else begin
            quarter <= next_quarter;
            o_quarter <= next_quarter_code;
            o_cycle_start <= next_cycle_start;
            o_osc_fault <= next_osc_fault;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Phase latches.

    logic [7:0] io_latch;
    logic [15:0] instr_latch;
    brm_ctl_t ctl_latch;
    logic [7:0] result_latch;
    logic [7:0] next_io_latch;
    logic [15:0] next_instr_latch;
    brm_ctl_t next_ctl_latch;
    logic [7:0] next_result_latch;

    always_comb begin
        next_io_latch = io_latch;
        next_instr_latch = instr_latch;
        next_ctl_latch = ctl_latch;
        next_result_latch = result_latch;
        // Transparent while the phase is open, holding once it closes.
        if (quarter == BRM_Q1) begin // RULE_14
            next_io_latch = io_sync; // RULE_10
            next_instr_latch = i_instr;
            next_ctl_latch = i_ctl;
        end
        if (quarter == BRM_Q3) begin // RULE_14
            next_result_latch = i_alu_result;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            io_latch <= RST_BYTE;
            instr_latch <= RST_INSTR;
            ctl_latch <= '0;
            result_latch <= RST_BYTE;
        end else begin
            io_latch <= next_io_latch;
            instr_latch <= next_instr_latch;
            ctl_latch <= next_ctl_latch;
            result_latch <= next_result_latch;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Rotate and mask ahead of the ALU.

    logic [2:0] rot_code;
    logic [3:0] len_now;
    logic [7:0] rot_src;
    logic [7:0] rot_out;

    // An I/O source takes its code from the instruction word itself.
    assign rot_code = ctl_latch.src_io ? instr_latch[INSTR_ROT_HI:INSTR_ROT_LO] : ctl_latch.r_field; // RULE_04
    assign len_now = len_decode(ctl_latch.len_field);
    assign rot_src = ctl_latch.src_io ? io_latch : i_reg_data;

    brm_rotate_mask #(
        .WIDTH(DATA_W)
    ) u_rotate_mask (
        .i_data(rot_src), // RULE_03
        .i_amount(code_to_places(rot_code)), // RULE_05
        .i_mask_en(ctl_latch.src_io), // RULE_02
        .i_len(len_now), // RULE_06
        .o_data(rot_out)
    );

    logic [7:0] next_alu_a;

    always_comb begin
        next_alu_a = o_alu_a;
        if (quarter == BRM_Q2) begin
            next_alu_a = rot_out; // RULE_01
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_alu_a <= RST_BYTE;
        end else begin
            o_alu_a <= next_alu_a;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shift and merge after the ALU.

    logic [2:0] pos_code;
    logic [7:0] merged;
    logic [7:0] merge_mask;

    assign pos_code = instr_latch[INSTR_POS_HI:INSTR_POS_LO];

    brm_shift_merge #(
        .WIDTH(DATA_W)
    ) u_shift_merge (
        .i_result(result_latch), // RULE_01
        .i_orig(io_latch), // RULE_11 RULE_12
        .i_amount(code_to_places(pos_code)), // RULE_08
        .i_len(len_now),
        .o_data(merged), // RULE_07
        .o_mask(merge_mask)
    );

    brm_io_drive_t next_io;

    always_comb begin
        next_io.oe = 1'b0;
        next_io.data = o_io.data;
        // Only whole bytes leave, and only during the output quarter.
        if (quarter == BRM_Q4 && ctl_latch.dst_io) begin // RULE_10
            next_io.oe = 1'b1;
            next_io.data = merged; // RULE_09
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_io <= '0;
        end else begin
            o_io <= next_io;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [2:0] edge_count;
    logic seen_start;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            edge_count <= 3'h0;
            seen_start <= 1'b0;
        end else begin
            if (o_cycle_start) begin
                edge_count <= sys_edge ? 3'h1 : 3'h0;
                seen_start <= 1'b1;
            end else if (sys_edge) begin
                edge_count <= edge_count + 3'h1;
            end
        end
    end

    a_quarter_wrap: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_13
        sys_edge && quarter == BRM_Q4 |=> quarter == BRM_Q1 ##0 o_cycle_start)
        else $error("Quarter sequence did not wrap to the first quarter.");

    a_cycle_edges: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_15
        o_cycle_start && seen_start |-> edge_count == 3'(OSC_EDGES_PER_CYCLE))
        else $error("Instruction cycle did not span two oscillator periods.");

    a_latch_hold: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_14
        quarter != BRM_Q1 |=> $stable(io_latch))
        else $error("I/O latch changed outside its open phase.");

    a_full_rotate: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_02
        quarter == BRM_Q2 && !ctl_latch.src_io && !ctl_latch.dst_io
        |=> $countones(o_alu_a) == $countones($past(i_reg_data)))
        else $error("Register to register operand lost bits.");

    a_no_rotate: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_17
        quarter == BRM_Q2 && ctl_latch.src_io && rot_code == CODE_LSB && len_now == LEN_FULL
        |=> o_alu_a == $past(io_latch))
        else $error("Code seven moved the operand.");

    a_mask_zero: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_06
        quarter == BRM_Q2 && ctl_latch.src_io |=> (o_alu_a >> $past(len_now)) == 8'h00)
        else $error("Bits above the field length reached the ALU.");

    a_merge_keep: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_09
        quarter == BRM_Q4 && ctl_latch.dst_io
        |=> o_io.oe && ((o_io.data ^ io_latch) & ~merge_mask) == 8'h00)
        else $error("Merge disturbed bits outside the field.");

    a_shift_top: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_07
        quarter == BRM_Q4 && ctl_latch.dst_io && pos_code == 3'h0
        |=> o_io.data == {$past(result_latch[0]), $past(io_latch[6:0])})
        else $error("Shift into the top bit wrapped or lost the field.");

    a_drive_window: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_10
        o_io.oe |-> $past(quarter == BRM_Q4 && ctl_latch.dst_io))
        else $error("I/O bus driven outside the output quarter.");

    a_osc_pair: assert property (@(posedge i_clk) disable iff (i_rst) // RULE_16
        osc_a_sync == osc_b_sync |=> o_osc_fault)
        else $error("Equal oscillator inputs went unreported.");

endmodule
`default_nettype wire

// >>> testbench/brm_io_partner.sv
`default_nettype none
module brm_io_partner
    import brm_pkg::*;
(
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst,
    // Pulse source controls.
    input wire logic [4:0] i_half,
    input wire logic i_stuck,
    // Port pins and the datapath's bus drive.
    input wire logic [7:0] i_pins,
    input wire brm_io_drive_t i_io,
    // Oscillator pair, bus level and port output latch.
    output logic o_osc_a,
    output logic o_osc_b,
    output logic [7:0] o_bus,
    output logic [7:0] o_port
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [4:0] cnt;
    logic osc;

    ////////////////////////////////////////
    // The half period can change at run time to pace the sequencer fast or slow.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt <= 5'h00;
            osc <= 1'b0;
        end else if (cnt >= i_half - 5'h01) begin
            cnt <= 5'h00;
            osc <= ~osc;
        end else begin
            cnt <= cnt + 5'h01;
        end
    end

    // The stuck control ties both inputs together only for the fault scenario.
    assign o_osc_a = osc;
    assign o_osc_b = i_stuck ? osc : ~osc;

    ////////////////////////////////////////
    // The bus carries the datapath's byte while it drives and the port pins otherwise.
    assign o_bus = i_io.oe ? i_io.data : i_pins;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_port <= 8'h00;
        end else if (i_io.oe) begin
            o_port <= i_io.data;
        end
    end
endmodule
`default_nettype wire

// >>> testbench/brm_bit_datapath_tb.sv
`default_nettype none
module brm_bit_datapath_tb
    import brm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        brm_ctl_t ctl;
        logic [15:0] instr;
        logic [7:0] rg;
        logic [7:0] io;
        logic [7:0] k;
        logic [7:0] exp_a;
        logic [7:0] exp_io;
    } brm_row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] instr = 16'h0000;
    brm_ctl_t ctl = '0;
    logic [7:0] reg_d = 8'h00;
    logic [7:0] pins = 8'h00;
    logic [7:0] k = 8'h00;
    logic [4:0] half = 5'h06;
    logic stuck = 1'b0;
    logic osc_a;
    logic osc_b;
    logic [7:0] bus;
    logic [7:0] port;
    logic [7:0] alu_a;
    logic [7:0] alu_res;
    brm_io_drive_t io;
    logic [1:0] quarter;
    logic cyc_start;
    logic osc_fault;
    logic [1:0] prev;
    int n;
    int steps;
    int failures = 0;
    int n_compared = 0;

    // Rows: control, instruction, register, port pins, ALU xor value, ALU A, bus byte.
    brm_row_t rows [0:8] = '{
        {8'h3B, 16'h0000, 8'hA5, 8'h00, 8'h00, 8'hA5, 8'h00},
        {8'h03, 16'h0300, 8'hA5, 8'h00, 8'h00, 8'h4B, 8'h00},
        {8'h1A, 16'h0000, 8'hA5, 8'h00, 8'h00, 8'h5A, 8'h00},
        {8'hC3, 16'h0407, 8'hFF, 8'hB4, 8'h00, 8'h06, 8'hB6},
        {8'hC0, 16'h0707, 8'h00, 8'h3C, 8'hFF, 8'h3C, 8'hC3},
        {8'hC1, 16'h0000, 8'h00, 8'h80, 8'h01, 8'h01, 8'h00},
        {8'hC4, 16'h0701, 8'h00, 8'h0F, 8'h05, 8'h0F, 8'h8F},
        {8'h6A, 16'h0005, 8'h06, 8'hF0, 8'h00, 8'h81, 8'hF4},
        {8'h85, 16'h0600, 8'h00, 8'h3F, 8'h00, 8'h1F, 8'h00}
    };

    always #4 clk = ~clk;

    // The ALU stand-in applies an xor so that the shift sees a value the rotate did not make.
    assign alu_res = alu_a ^ k;

    brm_bit_datapath dut (
        .i_clk(clk),
        .i_rst(rst),
        .i_osc_input_a(osc_a),
        .i_osc_input_b(osc_b),
        .i_instr(instr),
        .i_ctl(ctl),
        .i_reg_data(reg_d),
        .i_io_data(bus),
        .i_alu_result(alu_res),
        .o_alu_a(alu_a),
        .o_io(io),
        .o_quarter(quarter),
        .o_cycle_start(cyc_start),
        .o_osc_fault(osc_fault)
    );

    brm_io_partner partner (
        .i_clk(clk),
        .i_rst(rst),
        .i_half(half),
        .i_stuck(stuck),
        .i_pins(pins),
        .i_io(io),
        .o_osc_a(osc_a),
        .o_osc_b(osc_b),
        .o_bus(bus),
        .o_port(port)
    );

    ////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic wait_q(input logic [1:0] q);
        int w;
        w = 0;
        do begin
            @(negedge clk);
            w++;
        end while (quarter !== q && w < 400);
        chk("quarter_wait", {6'h00, quarter}, {6'h00, q});
    endtask

    // Inputs change in Q4, stand through a whole instruction cycle, and results are read in its Q4.
    task automatic run_row(input brm_row_t r);
        wait_q(2'd3);
        ctl <= r.ctl;
        instr <= r.instr;
        reg_d <= r.rg;
        pins <= r.io;
        k <= r.k;
        wait_q(2'd0);
        wait_q(2'd3);
        @(negedge clk);
        chk("alu_a", alu_a, r.exp_a);
        chk("io_oe", {7'h00, io.oe}, {7'h00, r.ctl.dst_io});
        if (r.ctl.dst_io) begin
            chk("io_data", io.data, r.exp_io);
            @(negedge clk);
            chk("port", port, r.exp_io);
        end
    endtask

    ////////////////////////////////////////
    initial begin
        repeat (5) @(negedge clk);
        chk("rst_quarter", {6'h00, quarter}, 8'h03);
        chk("rst_alu_a", alu_a, 8'h00);
        chk("rst_oe", {7'h00, io.oe}, 8'h00);
        chk("rst_fault", {7'h00, osc_fault}, 8'h00);
        rst <= 1'b0;
        wait_q(2'd0);
        chk("cyc_start", {7'h00, cyc_start}, 8'h01);
        n = 0;
        steps = 0;
        prev = quarter;
        do begin
            @(negedge clk);
            n++;
            if (quarter !== prev) begin
                chk("q_step", {6'h00, quarter}, {6'h00, prev + 2'd1});
                steps++;
                prev = quarter;
            end
        end while (cyc_start !== 1'b1 && n < 200);
        chk("cycle_len", n[7:0], 8'h18);
        chk("q_count", steps[7:0], 8'h04);
        @(negedge clk);
        chk("cyc_end", {7'h00, cyc_start}, 8'h00);
        for (int i = 0; i < 9; i++) begin
            half <= i[0] ? 5'h0C : 5'h06;
            run_row(rows[i]);
        end
        stuck <= 1'b1;
        repeat (8) @(negedge clk);
        chk("fault_set", {7'h00, osc_fault}, 8'h01);
        stuck <= 1'b0;
        repeat (8) @(negedge clk);
        chk("fault_clr", {7'h00, osc_fault}, 8'h00);
        wait_q(2'd2);
        rst <= 1'b1;
        repeat (3) @(negedge clk);
        chk("mid_quarter", {6'h00, quarter}, 8'h03);
        chk("mid_alu_a", alu_a, 8'h00);
        chk("mid_oe", {7'h00, io.oe}, 8'h00);
        rst <= 1'b0;
        run_row(rows[7]);
        end_sim();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        $display("[ERR] watchdog expected finish seen hang");
        end_sim();
    end
endmodule
`default_nettype wire
